// ==== src/oled_host_consts.svh ====
// Constants for the display host port: strap codes, command bytes, remap bits and timing.
// Included by the package and the interface module; it holds definitions only.
`ifndef OLED_HOST_CONSTS_SVH
`define OLED_HOST_CONSTS_SVH

// Strap pair {strap_b, strap_a}.
`define STRAP_SERIAL      2'h0
`define STRAP_SERIAL_ALT  2'h2
`define STRAP_M6800       2'h1
`define STRAP_I8080       2'h3

// Command bytes.
`define CMD_DISPLAY_ON    8'haf
`define CMD_DISPLAY_OFF   8'hae
`define CMD_REMAP         8'ha0

// Remap argument fields and reset value.
`define REMAP_COL_BIT     0
`define REMAP_NIBBLE_BIT  1
`define REMAP_ROW_BIT     4
`define REMAP_RESET       8'h00

// Display RAM geometry: bytes per row and number of rows.
`define RAM_COLS          64
`define RAM_ROWS          80
`define COL_W             6
`define ROW_W             7
`define SERIAL_BITS       4'h8

// Display-on settle time and clock rate.
`define DISPLAY_ON_MS     100
`define SYS_CLK_HZ        25000000
`define DISPLAY_ON_CYCLES ((`DISPLAY_ON_MS * `SYS_CLK_HZ) / 1000)

`endif

// ==== src/oled_host_pkg.sv ====
// Types shared by the display host port modules.
// Assumes the constants header sits beside it.
`include "oled_host_consts.svh"

package oled_host_pkg;

  typedef enum logic [1:0] {
    MODE_SERIAL = 2'h0,
    MODE_M6800  = 2'h1,
    MODE_I8080  = 2'h3
  } bus_mode_t;

  // Gray order along off, settling, on.
  typedef enum logic [1:0] {
    PWR_OFF    = 2'h0,
    PWR_SETTLE = 2'h1,
    PWR_ON     = 2'h3
  } power_state_t;

endpackage

// ==== src/byte_skid_buffer.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock, a synchronous active-high reset and a clock enable that freezes it.
`timescale 1ns/1ns

module byte_skid_buffer #(
  parameter int WIDTH = 9
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [0:1];
  logic [WIDTH-1:0] mem_d [0:1];
  logic             rd_q, rd_d;
  logic             wr_q, wr_d;
  logic [1:0]       cnt_q, cnt_d;
  logic             push, pop;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_d[0] = mem_q[0];
    mem_d[1] = mem_q[1];
    rd_d     = rd_q;
    wr_d     = wr_q;
    cnt_d    = cnt_q;
    if (push) begin
      mem_d[wr_q] = in_data;
      wr_d        = ~wr_q;
    end
    if (pop) begin
      rd_d = ~rd_q;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 2'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rd_q     <= 1'b0;
      wr_q     <= 1'b0;
      cnt_q    <= 2'h0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else if (clk_en) begin
      rd_q     <= rd_d;
      wr_q     <= wr_d;
      cnt_q    <= cnt_d;
      mem_q[0] <= mem_d[0];
      mem_q[1] <= mem_d[1];
    end
  end

endmodule

// ==== src/oled_host_interface.sv ====
// Host port of a grayscale display controller: 6800, 8080 or serial bus in, display RAM and
// command handling behind it. All pins are taken as synchronous to sys_clk.
//
// Functional notes
// - Transfers accepted only while chip select low.
// - Reset input low reinitialises all control state.
// - Data/command high sends byte to RAM.
// - Data/command low sends byte to commands.
// - 6800 transfer starts on enable rising edge.
// - 8080 write starts on write strobe low.
// - 8080 read starts on read strobe low.
// - Serial takes clock on line 0, data line 1.
// - Two straps pick 6800, 8080 or serial bus.
// - Data port bidirectional: host writes, device reads.
// - Display RAM holds 128x80 pixels, four bits each.
// - Software may remap columns and rows.
// - Low nibble even column, high nibble odd.
// - Bytes fill 64 columns, then next row.
// - Command AFh turns display on after 100 ms.
// - Command AEh turns display off.
`timescale 1ns/1ns
`include "oled_host_consts.svh"

module oled_host_interface
  import oled_host_pkg::*;
#(
  parameter int DISPLAY_ON_CYCLES = `DISPLAY_ON_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic       reset_in_n,
  input  wire logic       bus_select_strap_a,
  input  wire logic       bus_select_strap_b,
  input  wire logic       chip_select_n,
  input  wire logic       data_cmd,
  input  wire logic       rw_wr_n,
  input  wire logic       e_rd_n,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            host_ready,
  output logic            sink_valid,
  input  wire logic       sink_ready,
  output logic            sink_is_data,
  output logic      [7:0] sink_byte,
  output logic            display_enabled,
  output logic            col_remap,
  output logic            row_remap
);

  localparam int RAM_DEPTH = `RAM_COLS * `RAM_ROWS;
  localparam int CNT_W     = $clog2(DISPLAY_ON_CYCLES + 1);

  logic init;
  assign init = sys_rst || !reset_in_n;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Strap capture. Straps are only sampled while reset is held, so a strap that moves during
  // operation cannot switch the bus underneath a transfer.

  bus_mode_t mode_q, mode_d;

  always_comb begin
    mode_d = mode_q;
    if (init) begin
      case ({bus_select_strap_b, bus_select_strap_a})
        `STRAP_M6800: mode_d = MODE_M6800;
        `STRAP_I8080: mode_d = MODE_I8080;
        default:      mode_d = MODE_SERIAL;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      mode_q <= mode_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus front end: strobe edges, serial shifter and read data.

  logic       strobe_q, strobe_d;
  logic       wr_n_q, wr_n_d;
  logic       sclk_q, sclk_d;
  logic [7:0] shift_q, shift_d;
  logic [3:0] bits_q, bits_d;
  logic [7:0] rdata_q, rdata_d;
  logic       oe_q, oe_d;
  logic       wr_evt;
  logic       wr_dc;
  logic [7:0] wr_byte;
  logic       rd_evt;
  logic [7:0] ram_rd;
  logic [7:0] status_byte;

  always_comb begin
    strobe_d = e_rd_n;
    wr_n_d   = rw_wr_n;
    sclk_d   = data_in[0];
    shift_d  = shift_q;
    bits_d   = bits_q;
    rdata_d  = rdata_q;
    oe_d     = 1'b0;
    wr_evt   = 1'b0;
    rd_evt   = 1'b0;
    wr_dc    = data_cmd;
    wr_byte  = data_in;
    if (chip_select_n) begin
      bits_d = 4'h0;
    end else begin
      case (mode_q)
        MODE_M6800: begin
          if (e_rd_n && !strobe_q) begin
            wr_evt = !rw_wr_n;
            rd_evt = rw_wr_n;
          end
          oe_d = e_rd_n && rw_wr_n;
        end
        MODE_I8080: begin
          wr_evt = !rw_wr_n && wr_n_q;
          rd_evt = !e_rd_n && strobe_q;
          oe_d   = !e_rd_n;
        end
        default: begin
          if (data_in[0] && !sclk_q) begin
            shift_d = {shift_q[6:0], data_in[1]};
            if (bits_q == `SERIAL_BITS - 4'h1) begin
              bits_d  = 4'h0;
              wr_evt  = 1'b1;
              wr_byte = {shift_q[6:0], data_in[1]};
            end else begin
              bits_d = bits_q + 4'h1;
            end
          end
        end
      endcase
    end
    if (rd_evt) begin
      rdata_d = data_cmd ? ram_rd : status_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (init) begin
      strobe_q <= 1'b0;
      wr_n_q   <= 1'b1;
      sclk_q   <= 1'b0;
      shift_q  <= 8'h00;
      bits_q   <= 4'h0;
      rdata_q  <= 8'h00;
      oe_q     <= 1'b0;
    end else if (clk_en) begin
      strobe_q <= strobe_d;
      wr_n_q   <= wr_n_d;
      sclk_q   <= sclk_d;
      shift_q  <= shift_d;
      bits_q   <= bits_d;
      rdata_q  <= rdata_d;
      oe_q     <= oe_d;
    end
  end

  assign data_out = rdata_q;
  assign data_oe  = oe_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer. A byte arriving while it is full is dropped; host_ready tells the host
  // to pace itself, since none of the three buses can be held off by the device.

  logic       buf_ready;
  logic       drain;
  logic [8:0] buf_out;

  byte_skid_buffer #(
    .WIDTH (9)
  ) u_buffer (
    .sys_clk   (sys_clk),
    .sys_rst   (init),
    .clk_en    (clk_en),
    .in_valid  (wr_evt),
    .in_ready  (buf_ready),
    .in_data   ({wr_dc, wr_byte}),
    .out_valid (sink_valid),
    .out_ready (sink_ready),
    .out_data  (buf_out)
  );

  assign host_ready   = buf_ready;
  assign sink_is_data = buf_out[8];
  assign sink_byte    = buf_out[7:0];
  assign drain        = sink_valid && sink_ready;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Command handling: display power state, remap settings and the RAM write pointer.

  power_state_t         pwr_q, pwr_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [7:0]           remap_q, remap_d;
  logic                 arg_q, arg_d;
  logic [`COL_W-1:0]    col_q, col_d;
  logic [`ROW_W-1:0]    row_q, row_d;
  logic                 ram_we;

  always_comb begin
    pwr_d   = pwr_q;
    cnt_d   = cnt_q;
    remap_d = remap_q;
    arg_d   = arg_q;
    col_d   = col_q;
    row_d   = row_q;
    ram_we  = 1'b0;
    case (pwr_q)
      PWR_SETTLE: begin
        if (cnt_q == CNT_W'(DISPLAY_ON_CYCLES - 1)) begin
          pwr_d = PWR_ON;
        end else begin
          cnt_d = cnt_q + CNT_W'(1);
        end
      end
      PWR_ON:  pwr_d = PWR_ON;
      PWR_OFF: pwr_d = PWR_OFF;
      default: pwr_d = PWR_OFF;
    endcase
    if (drain) begin
      if (buf_out[8]) begin
        ram_we = 1'b1;
        if (col_q == `COL_W'(`RAM_COLS - 1)) begin
          col_d = '0;
          row_d = (row_q == `ROW_W'(`RAM_ROWS - 1)) ? '0 : row_q + `ROW_W'(1);
        end else begin
          col_d = col_q + `COL_W'(1);
        end
      end else if (arg_q) begin
        remap_d = buf_out[7:0];
        arg_d   = 1'b0;
      end else begin
        case (buf_out[7:0])
          `CMD_DISPLAY_ON: begin
            if (pwr_q == PWR_OFF) begin
              pwr_d = PWR_SETTLE;
              cnt_d = '0;
            end
          end
          `CMD_DISPLAY_OFF: pwr_d = PWR_OFF;
          `CMD_REMAP:       arg_d = 1'b1;
          default:          arg_d = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (init) begin
      pwr_q   <= PWR_OFF;
      cnt_q   <= '0;
      remap_q <= `REMAP_RESET;
      arg_q   <= 1'b0;
      col_q   <= '0;
      row_q   <= '0;
    end else if (clk_en) begin
      pwr_q   <= pwr_d;
      cnt_q   <= cnt_d;
      remap_q <= remap_d;
      arg_q   <= arg_d;
      col_q   <= col_d;
      row_q   <= row_d;
    end
  end

  assign display_enabled = (pwr_q == PWR_ON);
  assign col_remap       = remap_q[`REMAP_COL_BIT];
  assign row_remap       = remap_q[`REMAP_ROW_BIT];
  assign status_byte     = {display_enabled, 3'h0, remap_q[`REMAP_ROW_BIT], 1'b0,
                            remap_q[`REMAP_NIBBLE_BIT], remap_q[`REMAP_COL_BIT]};

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Display RAM, one byte per column address and two pixels per byte. The column and row remap settings act
  // on the stored location and the nibble swap on the stored byte, so the panel scan sees a mirrored image
  // without any read-side logic. The RAM is not cleared by reset; clearing 5120 bytes would cost a long sequencer.

  logic [7:0]           ram [0:RAM_DEPTH-1];
  logic [`COL_W-1:0]    col_m;
  logic [`ROW_W-1:0]    row_m;
  logic [12:0]          ram_idx;
  logic [7:0]           wr_pix;

  always_comb begin
    col_m = remap_q[`REMAP_COL_BIT] ? `COL_W'(`RAM_COLS - 1) - col_q : col_q;
    row_m = remap_q[`REMAP_ROW_BIT] ? `ROW_W'(`RAM_ROWS - 1) - row_q : row_q;
    ram_idx = {row_m, col_m};
    // Low nibble is the even column, high nibble the odd one unless nibbles are swapped.
    wr_pix = remap_q[`REMAP_NIBBLE_BIT] ? {buf_out[3:0], buf_out[7:4]} : buf_out[7:0];
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && ram_we && !init) begin
      ram[ram_idx] <= wr_pix;
    end
  end

  assign ram_rd = ram[ram_idx];

endmodule

// ==== dv/oled_host_interface_assertions.sv ====
// Concurrent checks on the ports of the display host port.
// Assumes clk_en is held high; bound to every instance below.
`timescale 1ns/1ns

module oled_host_interface_assertions #(
  parameter int DISPLAY_ON_CYCLES = 16
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       reset_in_n,
  input wire logic       chip_select_n,
  input wire logic       data_oe,
  input wire logic       host_ready,
  input wire logic       sink_valid,
  input wire logic       sink_ready,
  input wire logic       sink_is_data,
  input wire logic [7:0] sink_byte,
  input wire logic       display_enabled,
  input wire logic       col_remap,
  input wire logic       row_remap
);
  localparam int ON_LO = DISPLAY_ON_CYCLES - 1;
  localparam int ON_HI = DISPLAY_ON_CYCLES + 1;
  logic [7:0] on_cnt_q;
  logic [7:0] on_cnt_d;
  logic       cmd_go;
  assign cmd_go = sink_valid && sink_ready && !sink_is_data;
  // The counter saturates so a long idle time never wraps into a false match.
  always_comb begin
    on_cnt_d = (on_cnt_q == 8'hff) ? on_cnt_q : on_cnt_q + 8'h01;
    if (cmd_go && sink_byte == 8'haf) on_cnt_d = 8'h00;
  end
  always_ff @(posedge sys_clk) begin
    on_cnt_q <= sys_rst ? 8'hff : on_cnt_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst || !reset_in_n);
  property p_rst;
    disable iff (1'b0) sys_rst |=> host_ready && !sink_valid && !data_oe && !display_enabled;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_rstn;
    disable iff (1'b0) !reset_in_n |=> !display_enabled && !col_remap && !row_remap;
  endproperty
  a_rstn: assert property (p_rstn) else $error("pin reset state wrong");
  property p_cs;
    chip_select_n && !sink_valid |=> !sink_valid;
  endproperty
  a_cs: assert property (p_cs) else $error("byte taken while deselected");
  property p_oe;
    data_oe |-> !$past(chip_select_n);
  endproperty
  a_oe: assert property (p_oe) else $error("bus driven while deselected");
  property p_hold;
    sink_valid && !sink_ready |=> sink_valid && $stable(sink_byte) && $stable(sink_is_data);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");
  property p_full;
    !host_ready |-> sink_valid;
  endproperty
  a_full: assert property (p_full) else $error("full with nothing waiting");
  property p_on;
    $rose(display_enabled) |-> on_cnt_q >= ON_LO && on_cnt_q <= ON_HI;
  endproperty
  a_on: assert property (p_on) else $error("display on at wrong time");
  property p_stay;
    display_enabled && !(cmd_go && sink_byte == 8'hae) |=> display_enabled;
  endproperty
  a_stay: assert property (p_stay) else $error("display dropped by itself");
  property p_off;
    cmd_go && sink_byte == 8'hae |=> !display_enabled;
  endproperty
  a_off: assert property (p_off) else $error("display not off");
  c_on: cover property (cmd_go && sink_byte == 8'haf);
  c_full: cover property (!host_ready);
  c_read: cover property (data_oe);
endmodule

bind oled_host_interface oled_host_interface_assertions #(.DISPLAY_ON_CYCLES(DISPLAY_ON_CYCLES)) chk (
  .sys_clk, .sys_rst, .reset_in_n, .chip_select_n, .data_oe, .host_ready, .sink_valid, .sink_ready,
  .sink_is_data, .sink_byte, .display_enabled, .col_remap, .row_remap
);

// ==== dv/host_model.sv ====
// Host microcontroller model: 6800, 8080 and serial transfers on the port pins.
// Assumes the bench calls its tasks; pins change only at falling clock edges.
`timescale 1ns/1ns

module host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            chip_select_n,
  output logic            data_cmd,
  output logic            rw_wr_n,
  output logic            e_rd_n,
  output logic      [7:0] data_in
);
  logic [7:0] hd;
  logic       hdrv;
  logic       sel;
  // A released bus shows the inverse of the last byte, so stale data never passes.
  assign data_in = data_oe ? data_out : (hdrv ? hd : ~hd);
  initial begin
    chip_select_n = 1'b1;
    data_cmd = 1'b0;
    rw_wr_n = 1'b1;
    e_rd_n = 1'b1;
    hd = 8'h00;
    hdrv = 1'b0;
    sel = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic pw(input logic m68, input logic dc, input logic [7:0] b);
    @(negedge sys_clk);
    chip_select_n = sel;
    data_cmd = dc;
    hd = b;
    hdrv = 1'b1;
    rw_wr_n = 1'b0;
    if (m68) begin
      e_rd_n = 1'b0;
      @(negedge sys_clk);
      e_rd_n = 1'b1;
    end
    @(negedge sys_clk);
    e_rd_n = !m68;
    rw_wr_n = 1'b1;
    chip_select_n = 1'b1;
    hdrv = 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic pr(input logic m68, input logic dc, output logic [7:0] b);
    @(negedge sys_clk);
    chip_select_n = 1'b0;
    data_cmd = dc;
    hdrv = 1'b0;
    if (m68) begin
      rw_wr_n = 1'b1;
      e_rd_n = 1'b0;
      @(negedge sys_clk);
    end
    e_rd_n = m68;
    repeat (2) @(negedge sys_clk);
    b = data_out;
    e_rd_n = !m68;
    chip_select_n = 1'b1;
    @(negedge sys_clk);
  endtask
  // The serial clock stays low between frames.
  task automatic sw(input logic dc, input logic [7:0] b);
    @(negedge sys_clk);
    chip_select_n = sel;
    data_cmd = dc;
    hdrv = 1'b1;
    hd = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      @(negedge sys_clk);
      hd = {6'h00, b[i], 1'b0};
      @(negedge sys_clk);
      hd[0] = 1'b1;
    end
    @(negedge sys_clk);
    hd = 8'h00;
    chip_select_n = 1'b1;
    @(negedge sys_clk);
  endtask
endmodule

// ==== dv/test_oled_host_interface.sv ====
// Self-checking bench of the display host port in all three bus modes.
// Assumes the host model drives the bus pins and the bench plays the byte consumer.
`timescale 1ns/1ns

module test_oled_host_interface
  import oled_host_pkg::*;
;
  localparam int ON_CYC = 16;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       reset_in_n = 1'b1;
  logic       strap_a = 1'b1;
  logic       strap_b = 1'b1;
  logic       sink_ready = 1'b0;
  logic       chip_select_n, data_cmd, rw_wr_n, e_rd_n, data_oe, host_ready;
  logic       sink_valid, sink_is_data, display_enabled, col_remap, row_remap;
  logic [7:0] data_in, data_out, sink_byte, rb;
  int         err_total = 0;
  int         checked = 0;
  int         n;
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, s); end end

  always #20 sys_clk = ~sys_clk;
  host_model hm (.sys_clk, .data_out, .data_oe, .chip_select_n, .data_cmd, .rw_wr_n, .e_rd_n, .data_in);
  oled_host_interface #(.DISPLAY_ON_CYCLES(ON_CYC)) uut (
    .sys_clk, .sys_rst, .clk_en(1'b1), .reset_in_n, .bus_select_strap_a(strap_a),
    .bus_select_strap_b(strap_b), .chip_select_n, .data_cmd, .rw_wr_n, .e_rd_n, .data_in, .data_out,
    .data_oe, .host_ready, .sink_valid, .sink_ready, .sink_is_data, .sink_byte, .display_enabled,
    .col_remap, .row_remap
  );
  //////////////////////////////////////////////////////////////////////////////
  task automatic rst(input logic b, input logic a, input logic pin);
    @(negedge sys_clk);
    strap_b = b;
    strap_a = a;
    if (pin) reset_in_n = 1'b0;
    else sys_rst = 1'b1;
    // The pin reset stays low for 76 cycles, just over 3 us at 25 MHz.
    repeat (pin ? 76 : 2) @(negedge sys_clk);
    sys_rst = 1'b0;
    reset_in_n = 1'b1;
    @(negedge sys_clk);
    `CHK("reset", 6'h20, {host_ready, sink_valid, data_oe, display_enabled, col_remap, row_remap})
  endtask
  task automatic t_buffer();
    rst(1'b1, 1'b1, 1'b0);
    sink_ready = 1'b0;
    hm.pw(1'b0, 1'b1, 8'h3c);
    `CHK("data head", 10'h33c, {sink_valid, sink_is_data, sink_byte})
    hm.pw(1'b0, 1'b0, 8'h55);
    `CHK("full", 1'b0, host_ready)
    hm.pw(1'b0, 1'b1, 8'h99);
    sink_ready = 1'b1;
    @(negedge sys_clk);
    `CHK("cmd head", 10'h255, {sink_valid, sink_is_data, sink_byte})
    @(negedge sys_clk);
    `CHK("drained", 1'b0, sink_valid)
  endtask
  task automatic t_display();
    hm.pw(1'b0, 1'b0, 8'haf);
    n = 0;
    while (display_enabled !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    `CHK("on delay", 1'b1, n >= ON_CYC - 4 && n <= ON_CYC)
    hm.pr(1'b0, 1'b0, rb);
    `CHK("status", 8'h80, rb)
    hm.pw(1'b0, 1'b0, 8'hae);
    `CHK("off", 1'b0, display_enabled)
  endtask
  task automatic t_ram();
    rst(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 65; i++) hm.pw(1'b0, 1'b1, i[7:0]);
    rst(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 64; i++) hm.pw(1'b0, 1'b1, 8'hff);
    hm.pr(1'b0, 1'b1, rb);
    `CHK("second row", 8'h40, rb)
    // Column mirror plus nibble swap puts the first byte at byte 63 with its nibbles exchanged.
    rst(1'b1, 1'b1, 1'b0);
    hm.pw(1'b0, 1'b0, 8'ha0);
    hm.pw(1'b0, 1'b0, 8'h03);
    hm.pw(1'b0, 1'b1, 8'h5a);
    rst(1'b1, 1'b1, 1'b0);
    for (int i = 0; i < 63; i++) hm.pw(1'b0, 1'b1, 8'hff);
    hm.pr(1'b0, 1'b1, rb);
    `CHK("remapped byte", 8'ha5, rb)
  endtask
  task automatic t_m6800();
    rst(1'b0, 1'b1, 1'b0);
    hm.pw(1'b1, 1'b0, 8'ha0);
    hm.pw(1'b1, 1'b0, 8'h01);
    `CHK("remap", 2'h2, {col_remap, row_remap})
    hm.pr(1'b1, 1'b0, rb);
    `CHK("status", 8'h01, rb)
    hm.sel = 1'b1;
    hm.pw(1'b1, 1'b0, 8'haf);
    hm.sel = 1'b0;
    repeat (ON_CYC + 4) @(negedge sys_clk);
    `CHK("deselected", 1'b0, display_enabled)
    rst(1'b0, 1'b1, 1'b1);
  endtask
  task automatic t_serial(input logic b);
    rst(b, 1'b0, 1'b0);
    hm.sw(1'b0, 8'ha0);
    hm.sw(1'b0, 8'h10);
    `CHK("serial remap", 2'h1, {col_remap, row_remap})
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    err_total++;
    results();
  end
  initial begin
    t_buffer();
    t_display();
    t_ram();
    t_m6800();
    t_serial(1'b0);
    t_serial(1'b1);
    results();
  end
endmodule
